// ===== sbi_defines.vh
// register offsets, field positions and timing counts for the serial bit interface
`ifndef SBI_DEFINES_VH
`define SBI_DEFINES_VH
`define SBI_ADDR_DATA      8'hd9
`define SBI_ADDR_CONTROL   8'hd8
`define SBI_BIT_RX         7
`define SBI_BIT_TX         7
`define SBI_BIT_ATTN       6
`define SBI_BIT_READY      5
`define SBI_BIT_LOSS       4
`define SBI_BIT_START      3
`define SBI_BIT_STOP       2
`define SBI_BIT_MASTER     1
`define SBI_WR_CLR_XACT    7
`define SBI_WR_IDLE        6
`define SBI_WR_CLR_READY   5
`define SBI_WR_CLR_LOSS    4
`define SBI_WR_CLR_START   3
`define SBI_WR_CLR_STOP    2
`define SBI_WR_RSTART      1
`define SBI_WR_STOP        0
`define SBI_MIN_TIME_NS    4700
`define SBI_CLK_PERIOD_NS  5
`define SBI_MIN_CYCLES     ((`SBI_MIN_TIME_NS + `SBI_CLK_PERIOD_NS - 1) / `SBI_CLK_PERIOD_NS)
`define SBI_CNT_W          10
`endif

// ===== sbi_sync.v
// two flip-flop synchroniser for one pin level
module sbi_sync (
  // clock and reset
  input  wire ref_clk_i,
  input  wire rst_i,
  // level in and out
  input  wire d_i,
  output wire q_o
);
  reg meta_reg;
  reg sync_reg;
  // first stage feeds only the second stage; bus idles high
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end
  assign q_o = sync_reg;
endmodule

// ===== sbi_flag.v
// one sticky flag: set wins over clear
module sbi_flag (
  // clock and reset
  input  wire ref_clk_i,
  input  wire rst_i,
  // set and clear
  input  wire set_i,
  input  wire clr_i,
  output wire q_o
);
  reg flag_reg;
  // set has priority so an event in the clear cycle is kept
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else if (set_i) begin
      flag_reg <= 1'b1;
    end else if (clr_i) begin
      flag_reg <= 1'b0;
    end
  end
  assign q_o = flag_reg;
endmodule

// ===== sbi_core.v
// single-bit two-wire serial bus interface with control and data registers
// Function
// RULE_01: each scl rise latches sda as received bit, shown in bit 7 of both registers
// RULE_02: reading the data register clears data-ready and transmit-active
// RULE_03: writing the data register takes bit 7 as next bit to send
// RULE_04: writing the data register clears data-ready and sets transmit-active
// RULE_05: software must not use bit read-modify-write on the control register
// RULE_06: attention reads 1 when any of the four flags is set
// RULE_07: after data-ready sets, scl is held low until software clears it
// RULE_08: sda driven low and arbitration loss only while transmit-active; loss clears it
// RULE_09: any flag set stretches scl low; write 1 to clear bits clears each
// RULE_10: control writes of 1 are commands; bit 0 reads undefined
//
// limitations: no bus timeout timer, so a hung bus needs a system reset;
// the block never starts a frame on its own, software sends every bit;
// all pin levels pass two flip-flops, so pin events are seen about three
// clocks late, which is far below any legal bus phase at this clock.
//
// Chosen here: the plain strobed port.
`include "sbi_defines.vh"
module sbi_core (
  // clock and reset
  input  wire       ref_clk_i,
  input  wire       rst_i,
  // register port
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  // configuration levels
  input  wire       master_req_i,
  // two-wire bus pins, enables low while driving
  input  wire       scl_i,
  output wire       scl_o,
  output wire       scl_oe_n_o,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_n_o
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  wire scl_s;
  wire sda_s;
  reg  scl_d_reg;
  reg  sda_d_reg;
  sbi_sync u_sync_scl (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (scl_i),
    .q_o       (scl_s)
  );
  sbi_sync u_sync_sda (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (sda_i),
    .q_o       (sda_s)
  );
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  ////////////////////////////////////////////////////////////////////
  // register decode
  wire wr_data = wr_i & (addr_i == `SBI_ADDR_DATA);
  wire wr_ctrl = wr_i & (addr_i == `SBI_ADDR_CONTROL);
  wire rd_data = rd_i & (addr_i == `SBI_ADDR_DATA);
  // control writes act per bit: a 1 issues the command, a 0 does nothing
  // several commands may share one write, e.g. clear ready with a stop
  wire cmd_clr_xact  = wr_ctrl & wdata_i[`SBI_WR_CLR_XACT];
  wire cmd_idle      = wr_ctrl & wdata_i[`SBI_WR_IDLE];
  wire cmd_clr_ready = wr_ctrl & wdata_i[`SBI_WR_CLR_READY];
  wire cmd_clr_loss  = wr_ctrl & wdata_i[`SBI_WR_CLR_LOSS];
  wire cmd_clr_start = wr_ctrl & wdata_i[`SBI_WR_CLR_START];
  wire cmd_clr_stop  = wr_ctrl & wdata_i[`SBI_WR_CLR_STOP];
  wire cmd_rstart    = wr_ctrl & wdata_i[`SBI_WR_RSTART];
  wire cmd_stop      = wr_ctrl & wdata_i[`SBI_WR_STOP];

  ////////////////////////////////////////////////////////////////////
  // state registers
  reg rx_bit_reg;
  reg tx_bit_reg;
  reg tx_active_reg;
  reg idle_reg;
  reg busy_reg;
  reg master_reg;
  reg scl_hold_reg;
  reg sda_low_reg;
  reg rstart_pend_reg;
  reg stop_pend_reg;
  reg [`SBI_CNT_W-1:0] wait_cnt_reg;
  wire ready_flag;
  wire loss_flag;
  wire start_flag;
  wire stop_flag;

  // arbitration loss: released sda seen low at scl rise, foreign start, or sda high at scl rise while a stop is pending
  // only possible while transmit-active, so a listener never reports it
  wire loss_set = tx_active_reg &
                  ((scl_rise & tx_bit_reg & ~sda_s) |
                   (start_ev & ~sda_low_reg & ~rstart_pend_reg) |
                   (stop_pend_reg & scl_rise & sda_s)); // [RULE_08]
  // an idle-commanded slave ignores the bus until the next start
  wire slave_idle = idle_reg & ~master_reg;
  // data ready needs a frame in progress, so stray scl pulses are ignored
  wire ready_set = scl_rise & ~slave_idle & busy_reg;
  // own start and stop conditions do not raise the event flags
  wire start_set = start_ev & ~slave_idle & ~rstart_pend_reg;
  wire stop_set  = stop_ev & ~slave_idle & ~stop_pend_reg;

  // sticky flags, cleared by write-one; data ready also by data register access
  // the set input wins, so an event landing on the clearing access is kept
  // and software sees it on its next poll instead of losing a bit
  sbi_flag u_ready (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .set_i     (ready_set),
    .clr_i     (cmd_clr_ready | wr_data | rd_data), // [RULE_02] [RULE_04] [RULE_09]
    .q_o       (ready_flag)
  );
  // arbitration loss flag
  sbi_flag u_loss (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .set_i     (loss_set),
    .clr_i     (cmd_clr_loss), // [RULE_09]
    .q_o       (loss_flag)
  );
  // start condition seen flag
  sbi_flag u_start (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .set_i     (start_set),
    .clr_i     (cmd_clr_start), // [RULE_09]
    .q_o       (start_flag)
  );
  // stop condition seen flag
  sbi_flag u_stop (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .set_i     (stop_set),
    .clr_i     (cmd_clr_stop), // [RULE_09]
    .q_o       (stop_flag)
  );
  // attention is a plain or, so it follows the flags with no extra delay
  wire attention = ready_flag | loss_flag | start_flag | stop_flag; // [RULE_06]

  // received bit latch on every scl rise
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_bit_reg <= 1'b0;
    end else if (scl_rise) begin
      rx_bit_reg <= sda_s; // [RULE_01]
    end
  end

  // transmit bit and transmit-active state
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_bit_reg    <= 1'b1;
      tx_active_reg <= 1'b0;
    end else begin
      // a repeated start sends a one first, a stop a zero first
      if (wr_data) begin
        tx_bit_reg <= wdata_i[`SBI_BIT_TX]; // [RULE_03]
      end else if (cmd_rstart) begin
        tx_bit_reg <= 1'b1; // [RULE_10]
      end else if (cmd_stop) begin
        tx_bit_reg <= 1'b0; // [RULE_10]
      end
      // loss of arbitration overrides any access in the same cycle
      // so the line is released at once
      if (loss_set) begin
        tx_active_reg <= 1'b0; // [RULE_08]
      end else if (wr_data | cmd_rstart | cmd_stop) begin
        tx_active_reg <= 1'b1; // [RULE_04]
      end else if (rd_data | cmd_clr_xact) begin
        tx_active_reg <= 1'b0; // [RULE_02] [RULE_10]
      end
    end
  end

  // bus busy, idle-ignore and master state
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_reg   <= 1'b0;
      idle_reg   <= 1'b0;
      master_reg <= 1'b0;
    end else begin
      if (start_ev) begin
        busy_reg <= 1'b1;
      end else if (stop_ev) begin
        busy_reg <= 1'b0;
      end
      if (cmd_idle) begin
        idle_reg <= 1'b1; // [RULE_10]
      end else if (start_ev) begin
        idle_reg <= 1'b0;
      end
      // mastership ends on a lost arbitration or a stop sent after the
      // request was withdrawn; it starts only while no frame is running
      if (loss_set) begin
        master_reg <= 1'b0;
      end else if (cmd_stop & ~master_req_i) begin
        master_reg <= 1'b0;
      end else if (master_req_i & ~busy_reg & ~start_ev) begin
        master_reg <= 1'b1;
      end
    end
  end

  // repeated start / stop sequencing: wait minimum time with scl high
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rstart_pend_reg <= 1'b0;
      stop_pend_reg   <= 1'b0;
      wait_cnt_reg    <= {`SBI_CNT_W{1'b0}};
    end else begin
      // pending commands die with transmit-active, so a lost arbitration
      // or a clear command also cancels them
      if (cmd_rstart) begin
        rstart_pend_reg <= 1'b1;
      end else if (~tx_active_reg | (rstart_pend_reg & sda_low_reg & ~scl_s)) begin
        rstart_pend_reg <= 1'b0;
      end
      if (cmd_stop) begin
        stop_pend_reg <= 1'b1;
      end else if (~tx_active_reg | stop_ev) begin
        stop_pend_reg <= 1'b0;
      end
      if (~scl_s | ~(rstart_pend_reg | stop_pend_reg)) begin
        wait_cnt_reg <= {`SBI_CNT_W{1'b0}};
      end else if (wait_cnt_reg != `SBI_MIN_CYCLES) begin
        wait_cnt_reg <= wait_cnt_reg + 1'b1;
      end
    end
  end
  wire wait_done = (wait_cnt_reg == `SBI_MIN_CYCLES);

  // sda drive and scl hold
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_low_reg  <= 1'b0;
      scl_hold_reg <= 1'b0;
    end else begin
      // sda is only pulled while transmit-active; a changed bit waits for
      // scl low so that no false start or stop is made on the bus
      if (~tx_active_reg | loss_set) begin
        sda_low_reg <= 1'b0; // [RULE_08]
      end else if (rstart_pend_reg) begin
        sda_low_reg <= wait_done;
      end else if (stop_pend_reg) begin
        sda_low_reg <= ~wait_done;
      end else if (~scl_s) begin
        sda_low_reg <= ~tx_bit_reg; // change data only while scl low
      end
      // the hold starts only at a falling scl, so a high phase is never cut;
      // it ends once software has cleared every flag
      if (scl_fall & (attention | ready_set)) begin
        scl_hold_reg <= 1'b1; // [RULE_07] [RULE_09]
      end else if (~attention) begin
        scl_hold_reg <= 1'b0;
      end
    end
  end
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~(sda_low_reg & tx_active_reg); // [RULE_08]
  assign scl_o      = 1'b0;
  assign scl_oe_n_o = ~scl_hold_reg;

  ////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == `SBI_ADDR_DATA) begin
        rdata_o <= {rx_bit_reg, 7'h00}; // [RULE_01]
      end else if (addr_i == `SBI_ADDR_CONTROL) begin
        // bit 0 has no meaning on read and is given as zero
        rdata_o <= {rx_bit_reg, attention, ready_flag, loss_flag,
                    start_flag, stop_flag, master_reg, 1'b0}; // [RULE_10]
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

// ===== sbi_core_properties.sv
// concurrent checks on the register port and bus pins of the serial bit interface
`include "sbi_defines.vh"
module sbi_core_properties (
  // clock and reset
  input wire       ref_clk_i,
  input wire       rst_i,
  // register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  // bus pins
  input wire       scl_i,
  input wire       scl_oe_n_o,
  input wire       sda_oe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam [7:0] ad = `SBI_ADDR_DATA;
  localparam [7:0] ac = `SBI_ADDR_CONTROL;
  // accesses that may clear a flag, now and two cycles back
  wire       clr_now = wr_i | (rd_i & (addr_i == ad));
  reg  [1:0] clr_reg;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i)
      clr_reg <= 2'h0;
    else
      clr_reg <= {clr_reg[0], clr_now};
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  a_data_low_zero: assert property ($past(rd_i) && $past(addr_i) == ad |-> rdata_o[6:0] == 7'h00)
    else $error("data read shows bits below the received bit");
  a_attn_flags: assert property ($past(rd_i) && $past(addr_i) == ac |-> rdata_o[6] == |rdata_o[5:2])
    else $error("attention differs from the flags");
  a_ctl_bit0: assert property ($past(rd_i) && $past(addr_i) == ac |-> !rdata_o[0])
    else $error("control bit 0 not zero");
  a_read_clears_ready: assert property ((rd_i && addr_i == ad) ##1 (rd_i && addr_i == ac) |=> !rdata_o[5])
    else $error("data read left data ready set");
  a_write_clears_ready: assert property ((wr_i && addr_i == ad) ##1 (rd_i && addr_i == ac) |=> !rdata_o[5])
    else $error("data write left data ready set");
  a_read_drops_sda: assert property ((rd_i && addr_i == ad) ##1 !wr_i [*3] |=> sda_oe_n_o)
    else $error("sda driven after transmit stopped");
  a_one_drops_sda: assert property ((wr_i && addr_i == ad && wdata_i[7] && !scl_i) ##1 !wr_i [*3] |=> sda_oe_n_o)
    else $error("sda driven while sending a one");
  a_scl_holds: assert property (!scl_oe_n_o && !clr_now && clr_reg == 2'h0 |=> !scl_oe_n_o)
    else $error("scl released with no clearing access");
  a_scl_release: assert property (wr_i && addr_i == ac && wdata_i[5:2] == 4'hf |-> ##[1:4] scl_oe_n_o)
    else $error("scl still held after all flags cleared");
endmodule
bind sbi_core sbi_core_properties chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_i),
  .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o));

// ===== sbi_bus_model.sv
// behavioural master on the far side of the two-wire bus
module sbi_bus_model (
  // resolved bus levels
  input  wire  scl_w_i,
  input  wire  sda_w_i,
  // pull-down requests and sampled bit
  output logic scl_low_o = 1'b0,
  output logic sda_low_o = 1'b0,
  output logic got_o = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // kind 0 start, 1 data bit, 2 stop; 32 ns steps, scl high 32 ns and low 64 ns, scl idles high
  task automatic cyc(input int kind, input logic b, output logic ok);
    int n;
    ok = 1'b1;
    sda_low_o = (kind == 1) ? !b : 1'b1;
    #32;
    if (kind == 0) begin
      scl_low_o = 1'b1;
      #32;
      return;
    end
    scl_low_o = 1'b0;
    n = 0;
    // wait out clock stretching, bounded
    while (scl_w_i !== 1'b1 && n < 400) begin
      #4;
      n++;
    end
    ok = (n < 400);
    got_o = sda_w_i;
    #32;
    if (kind == 2)
      sda_low_o = 1'b0;
    else
      scl_low_o = 1'b1;
    #32;
  endtask
endmodule

// ===== sbi_core_bench.sv
// self-checking bench: register accesses against a bus model master
`include "sbi_defines.vh"
module sbi_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [7:0] ad = `SBI_ADDR_DATA;
  localparam [7:0] ac = `SBI_ADDR_CONTROL;
  logic       ref_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       master_req_i = 1'b0;
  wire  [7:0] rdata_o;
  wire        scl_oe_n_o, sda_oe_n_o, scl_low, sda_low, got;
  // open-drain lines with pull-ups
  wire        scl_w = scl_oe_n_o & ~scl_low;
  wire        sda_w = sda_oe_n_o & ~sda_low;
  int         fails = 0;
  int         comparisons = 0;
  logic       pend = 1'b0;
  logic [7:0] pexp = 8'h00;
  always #2.5 ref_clk_i = ~ref_clk_i;
  sbi_core dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .master_req_i(master_req_i), .scl_i(scl_w),
    .scl_o(), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(), .sda_oe_n_o(sda_oe_n_o));
  sbi_bus_model bus_u (.scl_w_i(scl_w), .sda_w_i(sda_w), .scl_low_o(scl_low),
    .sda_low_o(sda_low), .got_o(got));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one port cycle; a read from the cycle before is compared first
  task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    if (pend)
      chk("rdata_o", pexp, rdata_o);
    pend = r;
    pexp = d;
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, 1'b1, a, e);
    xfer(1'b0, 1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, 1'b0, a, d);
    xfer(1'b0, 1'b0, a, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) xfer(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic link(input int k, input logic b);
    logic ok;
    bus_u.cyc(k, b, ok);
    if (!ok) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic report_and_stop();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    idle(2);
    chk("sda_oe_n_o", 8'h01, {7'h00, sda_oe_n_o});
    link(0, 1'b0);
    idle(8);
    chk("scl_oe_n_o", 8'h00, {7'h00, scl_oe_n_o});
    wr(ac, 8'h3c);
    idle(4);
    chk("scl_oe_n_o", 8'h01, {7'h00, scl_oe_n_o});
    link(1, 1'b1);
    idle(4);
    chk("scl_oe_n_o", 8'h00, {7'h00, scl_oe_n_o});
    rd(ac, 8'he0);
    xfer(1'b0, 1'b1, ad, 8'h80);
    rd(ac, 8'h80);
    idle(3);
    chk("scl_oe_n_o", 8'h01, {7'h00, scl_oe_n_o});
    link(1, 1'b0);
    rd(ad, 8'h00);
    xfer(1'b1, 1'b0, ad, 8'h00);
    rd(ac, 8'h00);
    idle(4);
    chk("sda_oe_n_o", 8'h00, {7'h00, sda_oe_n_o});
    wr(ac, 8'h80);
    idle(3);
    chk("sda_oe_n_o", 8'h01, {7'h00, sda_oe_n_o});
    wr(ad, 8'h00);
    link(1, 1'b1);
    chk("got", 8'h00, {7'h00, got});
    rd(ac, 8'h60);
    wr(ad, 8'h80);
    link(1, 1'b0);
    rd(ac, 8'h70);
    idle(3);
    chk("sda_oe_n_o", 8'h01, {7'h00, sda_oe_n_o});
    wr(ac, 8'h3c);
    rd(ac, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'hda, 8'hff);
    rd(ac, 8'h00);
    link(2, 1'b0);
    rd(ac, 8'h64);
    wr(ac, 8'h3c);
    rd(ac, 8'h00);
    // bus is free after the stop: a master request is granted
    master_req_i <= 1'b1;
    idle(3);
    rd(ac, 8'h02);
    report_and_stop();
  end
endmodule
